// ==== common/esrsd_pkg.sv ====
// shared constants and types for engine speed and run-state detection
package esrsd_pkg;

  localparam int unsigned clock_hz = 50_000_000;
  localparam int unsigned freq_sel_hz = 55;
  localparam logic [15:0] freq_sel_centihz = 16'h157C;
  localparam int unsigned run_confirm_ms = 200;
  localparam int unsigned stop_confirm_ms = 5000;
  localparam int unsigned run_confirm_cycles = clock_hz / 1000 * run_confirm_ms;
  localparam int unsigned stop_confirm_cycles = clock_hz / 1000 * stop_confirm_ms;
  localparam int unsigned ms_cycles = clock_hz / 1000;

  localparam logic [15:0] volt_stop_pct_default = 16'h00AF;
  localparam logic [15:0] volt_start_pct_default = 16'h00C8;

  localparam logic [3:0] ain_oil_pressure = 4'h3;
  localparam logic [3:0] ain_temp_a = 4'h4;
  localparam logic [3:0] ain_temp_b = 4'h5;
  localparam logic [3:0] ain_level = 4'h5;

  localparam logic [15:0] press_r_lo = 16'h000A;
  localparam logic [15:0] press_r_hi = 16'h00B4;
  localparam logic [15:0] press_v_hi = 16'h0064;
  localparam logic [15:0] temp_r_lo = 16'h000A;
  localparam logic [15:0] temp_r_hi = 16'h0122;
  localparam logic [15:0] temp_v_lo = 16'h0028;
  localparam logic [15:0] temp_v_hi = 16'h0096;
  localparam logic [15:0] level_r_lo = 16'h000A;
  localparam logic [15:0] level_r_hi = 16'h00B4;
  localparam logic [15:0] level_v_hi = 16'h0064;

  typedef enum logic [1:0] {
    esrsd_src_none = 2'b00,
    esrsd_src_pickup = 2'b01,
    esrsd_src_wsig = 2'b11,
    esrsd_src_genfreq = 2'b10
  } esrsd_src_t;

  typedef enum logic [1:0] {
    esrsd_st_stopped = 2'b00,
    esrsd_st_running = 2'b01
  } esrsd_state_t;

  typedef struct packed {
    logic [15:0] stop_level;
    logic [15:0] start_level;
  } esrsd_thr_t;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } esrsd_meas_t;

endpackage

// ==== hw/esrsd_crit.sv ====
// hysteresis run criterion for one measured quantity
`timescale 1ns/1ns
module esrsd_crit
  import esrsd_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset
  input wire esrsd_meas_t meas, // measured value
  input wire esrsd_thr_t thr, // stop and start levels
  output logic enabled, // criterion is usable
  output logic running // running indication
);

  wire above_start = meas.value > thr.start_level;
  wire below_stop = meas.value < thr.stop_level;
  wire thr_ok = (thr.stop_level != 16'h0000) && (thr.start_level != 16'h0000) &&
                (thr.stop_level <= thr.start_level);

  assign enabled = meas.valid && thr_ok;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      running <= 1'b0;
    else if (!enabled)
      running <= 1'b0;
    else if (above_start)
      running <= 1'b1;
    else if (below_stop)
      running <= 1'b0;
  end

endmodule

// ==== hw/esrsd_curve.sv ====
// fixed two-point sensor curve, linear between endpoints
`timescale 1ns/1ns
module esrsd_curve
  import esrsd_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset
  input wire logic active, // curve selected on this input
  input wire logic [15:0] ohms, // sensor resistance
  input wire logic [15:0] r_lo, // low resistance endpoint
  input wire logic [15:0] r_hi, // high resistance endpoint
  input wire logic [15:0] v_at_lo, // value at low endpoint
  input wire logic [15:0] v_at_hi, // value at high endpoint
  output esrsd_meas_t result // converted value
);

  wire [15:0] r_clip = (ohms < r_lo) ? r_lo : ((ohms > r_hi) ? r_hi : ohms);
  wire [15:0] r_off = r_clip - r_lo;
  wire [15:0] r_span = r_hi - r_lo;
  wire rising = v_at_hi >= v_at_lo;
  wire [15:0] v_span = rising ? (v_at_hi - v_at_lo) : (v_at_lo - v_at_hi);
  wire [31:0] prod = r_off * v_span;
  wire [31:0] quot = prod / {16'h0000, r_span};
  wire [15:0] step = quot[15:0];
  wire [15:0] next_value = rising ? (v_at_lo + step) : (v_at_lo - step);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      result <= '0;
    else
      result <= '{valid: active, value: active ? next_value : 16'h0000};
  end

endmodule

// ==== hw/esrsd_top.sv ====
// engine speed source selection, sensor curves and run/stop detection
// Operation
// - rated speed picked by nominal frequency 55 Hz
// - nonzero tooth count uses pickup speed only
// - W frequency divided by W ratio
// - generator frequency times speed ratio
// - otherwise ECU speed when CAN enabled
// - analogue measurement beats ECU measurement
// - oil pressure curve only on input 3
// - temperature curves only on inputs 4, 5
// - level curves only on input 5
// - ECU running flag is criterion with CAN
// - speed criterion with hysteresis and validity
// - D+ criterion needs configured D+ input
// - oil criterion: delay, sensors, minimum pressure
// - generator voltage criterion with hysteresis
// - generator frequency criterion with hysteresis
// - any criterion running 0.2 s declares running
// - running drops starter, blocks new start
// - all enabled stopped 5 s declares stopped
// - optional overspeed alarm above speed limit
// - voltage thresholds percent of rated voltage
`timescale 1ns/1ns
module esrsd_top
  import esrsd_pkg::*;
#(
  parameter int unsigned run_cycles = run_confirm_cycles,
  parameter int unsigned stop_cycles = stop_confirm_cycles,
  parameter int unsigned ms_tick = ms_cycles
)
(
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [15:0] nominal_freq_centihz, // nominal frequency, 0.01 Hz
  input wire logic [15:0] rated_speed_primary, // rpm
  input wire logic [15:0] rated_speed_secondary, // rpm
  input wire logic [15:0] tooth_count, // pickup teeth, 0 off
  input wire logic [15:0] w_ratio, // W Hz per rev/s, 0 off
  input wire logic [15:0] speed_freq_ratio, // rpm per Hz, 0 off
  input wire logic can_enable, // CAN link enabled
  input wire logic [15:0] pickup_freq_hz, // pickup pulse frequency
  input wire logic [15:0] w_freq_hz, // alternator W frequency
  input wire logic [15:0] gen_freq_centihz, // generator frequency, 0.01 Hz
  input wire logic [15:0] gen_volt, // generator voltage, V
  input wire logic [15:0] rated_volt, // rated voltage, V
  input wire logic [15:0] volt_stop_pct, // 0.1 percent units
  input wire logic [15:0] volt_start_pct, // 0.1 percent units
  input wire esrsd_meas_t ecu_speed, // ECU speed over CAN
  input wire esrsd_meas_t ecu_oil_pressure, // ECU oil pressure
  input wire esrsd_meas_t ecu_oil_temp, // ECU oil temperature
  input wire esrsd_meas_t ecu_coolant_temp, // ECU coolant temperature
  input wire logic ecu_running, // ECU running indication
  input wire logic [15:0] ain_ohms [3:5], // analogue inputs 3..5, ohms
  input wire logic oil_pressure_fixed_curve_on3, // input 3 function
  input wire logic oil_temp_fixed_curve_on4, // input 4 function
  input wire logic oil_temp_fixed_curve_on5, // input 5 function
  input wire logic coolant_temp_fixed_curve_on4, // input 4 function
  input wire logic coolant_temp_fixed_curve_on5, // input 5 function
  input wire logic oil_level_fixed_curve_on5, // input 5 function
  input wire logic coolant_level_fixed_curve_on5, // input 5 function
  input wire logic fuel_level_fixed_curve_on5, // input 5 function
  input wire esrsd_thr_t speed_thr, // rpm stop/start
  input wire esrsd_thr_t dplus_thr, // D+ stop/start
  input wire esrsd_thr_t freq_thr, // 0.01 Hz stop/start
  input wire logic dplus_signal_function, // an input carries D+
  input wire logic [15:0] dplus_volt, // D+ voltage
  input wire logic [15:0] oil_delay_ms, // oil criterion delay, 0 off
  input wire logic [15:0] oil_min_pressure, // minimum pressure
  input wire logic oil_min_pressure_switch_cfg, // switch configured
  input wire logic oil_low_pressure_switch_cfg, // switch configured
  input wire logic oil_min_pressure_switch, // switch active, low pressure
  input wire logic oil_low_pressure_switch, // switch active, low pressure
  input wire logic overspeed_enable, // overspeed check on
  input wire logic [15:0] max_speed, // rpm limit
  input wire logic start_request, // starter wanted by sequencer
  output logic [15:0] rated_speed, // selected rated speed
  output logic [15:0] engine_speed, // rpm
  output logic speed_valid, // speed available
  output esrsd_src_t speed_source, // chosen source
  output esrsd_meas_t oil_pressure, // merged, bar*10
  output esrsd_meas_t oil_temp, // merged, deg C
  output esrsd_meas_t coolant_temp, // merged, deg C
  output esrsd_meas_t oil_level, // percent
  output esrsd_meas_t coolant_level, // percent
  output esrsd_meas_t fuel_level, // percent
  output logic engine_running, // declared running
  output logic starter_cmd, // starter motor drive
  output logic start_inhibit, // new start blocked
  output logic overspeed_alarm // overspeed
);

  //////////////////////////////////////////////////////////////////////////////
  // rated speed and speed source

  wire [15:0] next_rated = (nominal_freq_centihz < freq_sel_centihz) ? rated_speed_primary
                                                                     : rated_speed_secondary;
  wire use_pickup = tooth_count != 16'h0000;
  wire use_w = !use_pickup && (w_ratio != 16'h0000);
  wire use_gf = !use_pickup && !use_w && (speed_freq_ratio != 16'h0000);
  wire use_ecu = !use_pickup && !use_w && !use_gf && can_enable;

  wire [31:0] pickup_rpm = (32'(pickup_freq_hz) * 32'h3C) / (use_pickup ? 32'(tooth_count) : 32'h1);
  wire [31:0] w_rpm = (32'(w_freq_hz) * 32'h3C) / (use_w ? 32'(w_ratio) : 32'h1);
  wire [31:0] gf_rpm = (32'(gen_freq_centihz) * 32'(speed_freq_ratio)) / 32'h64;

  function automatic logic [15:0] sat16(input logic [31:0] v);
    sat16 = (v[31:16] != 16'h0000) ? 16'hFFFF : v[15:0];
  endfunction

  wire [15:0] next_speed = use_pickup ? sat16(pickup_rpm) : use_w ? sat16(w_rpm) :
                           use_gf ? sat16(gf_rpm) : use_ecu ? ecu_speed.value : 16'h0000;
  wire next_speed_valid = use_pickup || use_w || use_gf || (use_ecu && ecu_speed.valid);
  wire esrsd_src_t next_src = use_pickup ? esrsd_src_pickup : use_w ? esrsd_src_wsig :
                              use_gf ? esrsd_src_genfreq : esrsd_src_none;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rated_speed <= 16'h0000;
      engine_speed <= 16'h0000;
      speed_valid <= 1'b0;
      speed_source <= esrsd_src_none;
    end
    else
    begin
      rated_speed <= next_rated;
      engine_speed <= next_speed;
      speed_valid <= next_speed_valid;
      speed_source <= next_src;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // analogue fixed curves

  esrsd_meas_t c_press, c_otemp4, c_otemp5, c_ctemp4, c_ctemp5, c_olvl, c_clvl, c_flvl;

  esrsd_curve u_press (.clock(clock), .rst_n(rst_n), .active(oil_pressure_fixed_curve_on3),
    .ohms(ain_ohms[3]), .r_lo(press_r_lo), .r_hi(press_r_hi), .v_at_lo(16'h0000),
    .v_at_hi(press_v_hi), .result(c_press));
  esrsd_curve u_otemp4 (.clock(clock), .rst_n(rst_n), .active(oil_temp_fixed_curve_on4),
    .ohms(ain_ohms[4]), .r_lo(temp_r_lo), .r_hi(temp_r_hi), .v_at_lo(temp_v_hi),
    .v_at_hi(temp_v_lo), .result(c_otemp4));
  esrsd_curve u_otemp5 (.clock(clock), .rst_n(rst_n), .active(oil_temp_fixed_curve_on5),
    .ohms(ain_ohms[5]), .r_lo(temp_r_lo), .r_hi(temp_r_hi), .v_at_lo(temp_v_hi),
    .v_at_hi(temp_v_lo), .result(c_otemp5));
  esrsd_curve u_ctemp4 (.clock(clock), .rst_n(rst_n), .active(coolant_temp_fixed_curve_on4),
    .ohms(ain_ohms[4]), .r_lo(temp_r_lo), .r_hi(temp_r_hi), .v_at_lo(temp_v_hi),
    .v_at_hi(temp_v_lo), .result(c_ctemp4));
  esrsd_curve u_ctemp5 (.clock(clock), .rst_n(rst_n), .active(coolant_temp_fixed_curve_on5),
    .ohms(ain_ohms[5]), .r_lo(temp_r_lo), .r_hi(temp_r_hi), .v_at_lo(temp_v_hi),
    .v_at_hi(temp_v_lo), .result(c_ctemp5));
  esrsd_curve u_olvl (.clock(clock), .rst_n(rst_n), .active(oil_level_fixed_curve_on5),
    .ohms(ain_ohms[5]), .r_lo(level_r_lo), .r_hi(level_r_hi), .v_at_lo(level_v_hi),
    .v_at_hi(16'h0000), .result(c_olvl));
  esrsd_curve u_clvl (.clock(clock), .rst_n(rst_n), .active(coolant_level_fixed_curve_on5),
    .ohms(ain_ohms[5]), .r_lo(level_r_lo), .r_hi(level_r_hi), .v_at_lo(level_v_hi),
    .v_at_hi(16'h0000), .result(c_clvl));
  esrsd_curve u_flvl (.clock(clock), .rst_n(rst_n), .active(fuel_level_fixed_curve_on5),
    .ohms(ain_ohms[5]), .r_lo(level_r_lo), .r_hi(level_r_hi), .v_at_lo(level_v_hi),
    .v_at_hi(16'h0000), .result(c_flvl));

  function automatic esrsd_meas_t pick(input esrsd_meas_t ana, input esrsd_meas_t ecu, input logic can);
    pick = ana.valid ? ana : ((can && ecu.valid) ? ecu : '0);
  endfunction

  wire esrsd_meas_t otemp_ana = c_otemp4.valid ? c_otemp4 : c_otemp5;
  wire esrsd_meas_t ctemp_ana = c_ctemp4.valid ? c_ctemp4 : c_ctemp5;

  assign oil_pressure = pick(c_press, ecu_oil_pressure, can_enable);
  assign oil_temp = pick(otemp_ana, ecu_oil_temp, can_enable);
  assign coolant_temp = pick(ctemp_ana, ecu_coolant_temp, can_enable);
  assign oil_level = c_olvl;
  assign coolant_level = c_clvl;
  assign fuel_level = c_flvl;

  //////////////////////////////////////////////////////////////////////////////
  // run criteria

  wire [31:0] v_stop_w = (32'(rated_volt) * 32'(volt_stop_pct)) / 32'h3E8;
  wire [31:0] v_start_w = (32'(rated_volt) * 32'(volt_start_pct)) / 32'h3E8;
  wire esrsd_thr_t volt_thr = '{stop_level: sat16(v_stop_w), start_level: sat16(v_start_w)};

  logic en_speed, run_speed, en_dplus, run_dplus, en_volt, run_volt, en_freq, run_freq;

  esrsd_crit u_speed (.clock(clock), .rst_n(rst_n), .meas('{valid: speed_valid, value: engine_speed}),
    .thr(speed_thr), .enabled(en_speed), .running(run_speed));
  esrsd_crit u_dplus (.clock(clock), .rst_n(rst_n), .meas('{valid: dplus_signal_function, value: dplus_volt}),
    .thr(dplus_thr), .enabled(en_dplus), .running(run_dplus));
  esrsd_crit u_volt (.clock(clock), .rst_n(rst_n), .meas('{valid: 1'b1, value: gen_volt}),
    .thr(volt_thr), .enabled(en_volt), .running(run_volt));
  esrsd_crit u_freq (.clock(clock), .rst_n(rst_n), .meas('{valid: 1'b1, value: gen_freq_centihz}),
    .thr(freq_thr), .enabled(en_freq), .running(run_freq));

  wire en_ecu = can_enable;
  wire run_ecu = can_enable && ecu_running;

  // oil: low when measured below minimum, or a configured switch is active
  wire oil_sensed = oil_min_pressure_switch_cfg || oil_low_pressure_switch_cfg || oil_pressure.valid;
  wire en_oil = (oil_delay_ms != 16'h0000) && oil_sensed;
  wire oil_low = (oil_pressure.valid && (oil_pressure.value < oil_min_pressure)) ||
                 (oil_min_pressure_switch_cfg && oil_min_pressure_switch) ||
                 (oil_low_pressure_switch_cfg && oil_low_pressure_switch);
  logic [31:0] oil_tick;
  logic [15:0] oil_ms;
  logic run_oil;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oil_tick <= 32'h0000_0000;
      oil_ms <= 16'h0000;
      run_oil <= 1'b0;
    end
    else if (!en_oil || oil_low)
    begin
      oil_tick <= 32'h0000_0000;
      oil_ms <= 16'h0000;
      run_oil <= 1'b0;
    end
    else if (oil_ms >= oil_delay_ms)
      run_oil <= 1'b1;
    else if (oil_tick >= 32'(ms_tick - 1))
    begin
      oil_tick <= 32'h0000_0000;
      oil_ms <= oil_ms + 16'h0001;
    end
    else
      oil_tick <= oil_tick + 32'h0000_0001;
  end

  //////////////////////////////////////////////////////////////////////////////
  // running / stopped declaration

  wire any_run = (en_ecu && run_ecu) || (en_speed && run_speed) || (en_dplus && run_dplus) ||
                 (en_oil && run_oil) || (en_volt && run_volt) || (en_freq && run_freq);
  wire all_stop = !any_run;

  esrsd_state_t state;
  logic [31:0] dwell;
  wire run_done = dwell >= 32'(run_cycles - 1);
  wire stop_done = dwell >= 32'(stop_cycles - 1);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= esrsd_st_stopped;
      dwell <= 32'h0000_0000;
    end
    else
    begin
      case (state)
        esrsd_st_stopped:
        begin
          if (!any_run)
            dwell <= 32'h0000_0000;
          else if (run_done)
          begin
            state <= esrsd_st_running;
            dwell <= 32'h0000_0000;
          end
          else
            dwell <= dwell + 32'h0000_0001;
        end
        esrsd_st_running:
        begin
          if (!all_stop)
            dwell <= 32'h0000_0000;
          else if (stop_done)
          begin
            state <= esrsd_st_stopped;
            dwell <= 32'h0000_0000;
          end
          else
            dwell <= dwell + 32'h0000_0001;
        end
        default:
        begin
          state <= esrsd_st_stopped;
          dwell <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign engine_running = state == esrsd_st_running;
  assign start_inhibit = engine_running;
  assign starter_cmd = start_request && !engine_running;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      overspeed_alarm <= 1'b0;
    else
      overspeed_alarm <= overspeed_enable && speed_valid && (max_speed != 16'h0000) &&
                         (engine_speed > max_speed);
  end

endmodule

// ==== verif/esrsd_partner.sv ====
// engine model: turns a shaft speed into sensor and ECU signals
`timescale 1ns/1ns
module esrsd_partner
  import esrsd_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic [15:0] rpm, // true shaft speed
  output logic [15:0] pickup_freq_hz, // 60 teeth wheel
  output logic [15:0] w_freq_hz, // 3 Hz per rev/s
  output logic [15:0] gen_freq_centihz, // 30 rpm per Hz
  output logic [15:0] gen_volt, // 400 V at 1500 rpm
  output logic [15:0] dplus_volt, // charger output
  output esrsd_meas_t ecu_speed, // ECU speed report
  output logic ecu_running // ECU own verdict
);
  // sensors sample the shaft once a cycle
  always_ff @(posedge clock)
  begin
    pickup_freq_hz <= rpm;
    w_freq_hz <= rpm / 16'h0014;
    gen_freq_centihz <= rpm * 16'h000A / 16'h0003;
    gen_volt <= rpm * 16'h0004 / 16'h000F;
    dplus_volt <= (rpm != 16'h0000) ? 16'h001C : 16'h0000;
    ecu_speed <= '{1'b1, rpm};
    ecu_running <= rpm > 16'h0064;
  end
endmodule

// ==== verif/esrsd_asserts.sv ====
// concurrent checks on the run-state detector ports
`timescale 1ns/1ns
module esrsd_asserts
  import esrsd_pkg::*;
#(
  parameter int unsigned run_cycles = run_confirm_cycles,
  parameter int unsigned stop_cycles = stop_confirm_cycles
)
(
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset
  input wire logic [15:0] nominal_freq_centihz, // nominal frequency
  input wire logic [15:0] rated_speed_primary, // rpm
  input wire logic [15:0] rated_speed_secondary, // rpm
  input wire logic [15:0] tooth_count, // pickup teeth
  input wire logic [15:0] w_ratio, // W ratio
  input wire logic [15:0] speed_freq_ratio, // rpm per Hz
  input wire logic [15:0] ain_ohms [3:5], // analogue inputs
  input wire logic fuel_level_fixed_curve_on5, // level curve on
  input wire logic overspeed_enable, // overspeed check on
  input wire logic start_request, // starter wanted
  input wire logic [15:0] rated_speed, // selected rated speed
  input wire esrsd_src_t speed_source, // chosen source
  input wire esrsd_meas_t fuel_level, // percent
  input wire logic engine_running, // declared running
  input wire logic starter_cmd, // starter drive
  input wire logic start_inhibit, // start blocked
  input wire logic overspeed_alarm // overspeed
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [31:0] age;
  logic last_run;
  ////////////////////////////////////////////////////////////////
  // cycles that engine_running has held its level
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      age <= 32'h0000_0000;
      last_run <= 1'b0;
    end
    else
    begin
      last_run <= engine_running;
      age <= (engine_running != last_run) ? 32'h0000_0001 : age + 32'h0000_0001;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_starter_gate: assert property (starter_cmd == (start_request && !engine_running))
    else $error("starter drive not gated by running");
  a_start_block: assert property (start_inhibit == engine_running)
    else $error("start inhibit differs from running");
  a_rated_pick: assert property (rst_n |=> rated_speed == (($past(nominal_freq_centihz) < freq_sel_centihz) ?
    $past(rated_speed_primary) : $past(rated_speed_secondary))) else $error("wrong rated speed");
  a_pickup_first: assert property (tooth_count != 16'h0000 |=> speed_source == esrsd_src_pickup)
    else $error("pickup not chosen");
  a_wsig_next: assert property (tooth_count == 16'h0000 && w_ratio != 16'h0000 |=> speed_source == esrsd_src_wsig)
    else $error("W source not chosen");
  a_genfreq_next: assert property ((tooth_count | w_ratio) == 16'h0000 && speed_freq_ratio != 16'h0000
    |=> speed_source == esrsd_src_genfreq) else $error("frequency source not chosen");
  a_run_confirm: assert property ($rose(engine_running) |-> age >= run_cycles - 2)
    else $error("running declared too early");
  a_stop_confirm: assert property ($fell(engine_running) |-> age >= stop_cycles - 2)
    else $error("stopped declared too early");
  a_overspeed_off: assert property (!overspeed_enable |=> !overspeed_alarm)
    else $error("overspeed alarm while check off");
  a_fuel_curve: assert property (fuel_level_fixed_curve_on5 && ain_ohms[5] == level_r_lo
    |=> fuel_level.valid && fuel_level.value == level_v_hi) else $error("fuel level curve endpoint wrong");
  cover property ($rose(engine_running));
  cover property ($fell(engine_running));
  cover property ($rose(overspeed_alarm));
endmodule
bind esrsd_top esrsd_asserts #(.run_cycles(run_cycles), .stop_cycles(stop_cycles)) u_esrsd_asserts (.*);

// ==== verif/esrsd_top_tb.sv ====
// self-checking bench for engine speed and run-state detection
`timescale 1ns/1ns
module esrsd_top_tb;
  import esrsd_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] nominal_freq_centihz = '0, rated_speed_primary = 16'h05DC, rated_speed_secondary = 16'h0708;
  logic [15:0] tooth_count = '0, w_ratio = '0, speed_freq_ratio = '0, rated_volt = 16'h0190, rpm = '0;
  logic [15:0] volt_stop_pct = '0, volt_start_pct = '0, oil_delay_ms = '0, oil_min_pressure = 16'h0014;
  logic [15:0] max_speed = 16'h05DC;
  logic [15:0] ain_ohms [3:5] = '{16'h000A, 16'h000A, 16'h000A};
  logic can_enable = '0, dplus_signal_function = '0, overspeed_enable = '0, start_request = '0;
  logic oil_pressure_fixed_curve_on3 = '0, oil_temp_fixed_curve_on4 = '0, oil_temp_fixed_curve_on5 = '0;
  logic coolant_temp_fixed_curve_on4 = '0, coolant_temp_fixed_curve_on5 = '0, oil_level_fixed_curve_on5 = '0;
  logic coolant_level_fixed_curve_on5 = '0, fuel_level_fixed_curve_on5 = '0, oil_min_pressure_switch_cfg = '0;
  logic oil_low_pressure_switch_cfg = '0, oil_min_pressure_switch = '0, oil_low_pressure_switch = '0;
  esrsd_meas_t ecu_oil_pressure = '0, ecu_oil_temp = '0, ecu_coolant_temp = '0;
  esrsd_thr_t speed_thr = '0, dplus_thr = '0, freq_thr = '0;
  logic [15:0] pickup_freq_hz, w_freq_hz, gen_freq_centihz, gen_volt, dplus_volt, rated_speed, engine_speed;
  logic speed_valid, ecu_running, engine_running, starter_cmd, start_inhibit, overspeed_alarm;
  esrsd_src_t speed_source;
  esrsd_meas_t ecu_speed, oil_pressure, oil_temp, coolant_temp, oil_level, coolant_level, fuel_level;
  int fail_count = 0;
  int cmp_count = 0;

  esrsd_partner u_esrsd_partner (.*);
  esrsd_top #(.run_cycles(20), .stop_cycles(50), .ms_tick(4)) u_esrsd_top (.*);

  initial
  begin
    forever #10 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic src(input logic [15:0] t, w, s, input logic c, input logic [15:0] e, input esrsd_src_t es);
    @(posedge clock);
    tooth_count <= t;
    w_ratio <= w;
    speed_freq_ratio <= s;
    can_enable <= c;
    cyc(3);
    chk(engine_speed, e);
    chk(speed_source, es);
    chk(speed_valid, 1'b1);
  endtask

  task automatic ovs(input logic [15:0] r, input logic en, input logic exp);
    @(posedge clock);
    rpm <= r;
    overspeed_enable <= en;
    cyc(4);
    chk(overspeed_alarm, exp);
  endtask

  task automatic runchk(input int n, input logic e);
    cyc(n);
    chk(engine_running, e);
    chk(starter_cmd, !e);
    chk(start_inhibit, e);
  endtask

  // one criterion enabled, or one left disabled by its settings
  task automatic setup(input int k);
    @(posedge clock);
    case (k)
      0: speed_thr <= '{16'h012C, 16'h0258};
      1: dplus_signal_function <= 1'b1;
      2: oil_delay_ms <= 16'h0002;
      3: volt_stop_pct <= volt_stop_pct_default;
      4: freq_thr <= '{16'h03E8, 16'h07D0};
      5: can_enable <= 1'b1;
      6: speed_thr <= '{16'h0258, 16'h012C};
      7: dplus_signal_function <= 1'b0;
      8: oil_min_pressure_switch_cfg <= 1'b1;
      9: volt_stop_pct <= 16'h00FA;
      10: freq_thr <= '{16'h0000, 16'h07D0};
      default: speed_thr <= '{16'h012C, 16'h0000};
    endcase
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rpm <= 16'h04B0;
    nominal_freq_centihz <= freq_sel_centihz - 16'h0001;
    cyc(3);
    chk(rated_speed, 16'h05DC);
    @(posedge clock);
    nominal_freq_centihz <= freq_sel_centihz;
    cyc(3);
    chk(rated_speed, 16'h0708);
    src(16'h001E, 16'h0003, 16'h001E, 1'b1, 16'h0960, esrsd_src_pickup);
    src(16'h0000, 16'h0006, 16'h001E, 1'b1, 16'h0258, esrsd_src_wsig);
    src(16'h0000, 16'h0000, 16'h000F, 1'b1, 16'h0258, esrsd_src_genfreq);
    src(16'h0000, 16'h0000, 16'h0000, 1'b1, 16'h04B0, esrsd_src_none);
    @(posedge clock);
    ecu_oil_pressure <= '{1'b1, 16'h004D};
    ecu_oil_temp <= '{1'b1, 16'h0063};
    ecu_coolant_temp <= '{1'b1, 16'h0063};
    ain_ohms[3] <= 16'h005F;
    ain_ohms[4] <= 16'h0122;
    oil_temp_fixed_curve_on4 <= 1'b1;
    coolant_temp_fixed_curve_on5 <= 1'b1;
    oil_level_fixed_curve_on5 <= 1'b1;
    coolant_level_fixed_curve_on5 <= 1'b1;
    fuel_level_fixed_curve_on5 <= 1'b1;
    cyc(3);
    chk(oil_pressure.value, 16'h004D);
    chk(oil_temp.value, 16'h0028);
    chk(coolant_temp.value, 16'h0096);
    chk(oil_level.value, 16'h0064);
    chk(coolant_level.value, 16'h0064);
    @(posedge clock);
    oil_pressure_fixed_curve_on3 <= 1'b1;
    ain_ohms[5] <= 16'h00B4;
    cyc(3);
    chk(oil_pressure.value, 16'h0032);
    chk(fuel_level.value, 16'h0000);
    src(16'h003C, 16'h0000, 16'h0000, 1'b0, 16'h04B0, esrsd_src_pickup);
    ovs(16'h0640, 1'b1, 1'b1);
    ovs(16'h0640, 1'b0, 1'b0);
    ovs(16'h0578, 1'b1, 1'b0);
    @(posedge clock);
    volt_start_pct <= volt_start_pct_default;
    dplus_thr <= '{16'h0005, 16'h000A};
    start_request <= 1'b1;
    runchk(60, 1'b0);
    for (int k = 0; k < 12; k++)
    begin
      @(posedge clock);
      rpm <= 16'h0000;
      speed_thr <= '0;
      freq_thr <= '0;
      volt_stop_pct <= '0;
      dplus_signal_function <= 1'b0;
      oil_delay_ms <= '0;
      can_enable <= 1'b0;
      oil_min_pressure_switch_cfg <= 1'b0;
      ain_ohms[3] <= 16'h005F;
      setup(k);
      @(posedge clock);
      rpm <= 16'h05DC;
      runchk(15, 1'b0);
      runchk(30, k < 6);
      @(posedge clock);
      rpm <= 16'h01C2;
      runchk(70, k < 6);
      @(posedge clock);
      rpm <= 16'h0000;
      ain_ohms[3] <= 16'h000A;
      runchk(30, k < 6);
      runchk(40, 1'b0);
    end
    stop_test();
  end
endmodule
